// [ccb_action.v]
// Action stage: applies a two-bit action code to one PWM output level.
// Assumes the event input is a one-cycle pulse.
`timescale 1ns/100ps
`include "ccb_defines.vh"
module ccb_action (
  // Inputs.
  input  wire [1:0] act_i,
  input  wire       event_i,
  input  wire       level_i,
  // Next level.
  output reg        level_o
);
  // ==========================================================================
  // Apply action
  always @* begin
    level_o = level_i;
    if (event_i) begin
      case (act_i)                                             // [RQ4]
        `CCB_ACT_LOW:    level_o = 1'b0;
        `CCB_ACT_HIGH:   level_o = 1'b1;
        `CCB_ACT_TOGGLE: level_o = ~level_i;
        default:         level_o = level_i;
      endcase
    end
  end
endmodule // ccb_action

// [ccb_defines.vh]
// Constants for the compare-B unit: register offsets, field positions, reset values, encodings.
// Assumes a 32-bit classic Wishbone slave with word-aligned registers.
`ifndef CCB_DEFINES_VH
`define CCB_DEFINES_VH
// ==========================================================================
// Register byte offsets
`define CCB_OFS_CMP_A        4'h0
`define CCB_OFS_CMP_B        4'h4
`define CCB_OFS_CTRL         4'h8
`define CCB_OFS_ACT_A        4'hC
// ==========================================================================
// Control register fields
`define CCB_A_LOAD_LO        0
`define CCB_A_LOAD_HI        1
`define CCB_B_LOAD_LO        2
`define CCB_B_LOAD_HI        3
`define CCB_A_BUF_BIT        4
`define CCB_B_BUF_BIT        6
`define CCB_A_PEND_BIT       8
`define CCB_B_PEND_BIT       9
// ==========================================================================
// Action control fields: compare-B action for output A in [1:0], output B in [3:2].
`define CCB_ACT_OUTA_LO      0
`define CCB_ACT_OUTA_HI      1
`define CCB_ACT_OUTB_LO      2
`define CCB_ACT_OUTB_HI      3
`define CCB_ACT_W            4
// ==========================================================================
// Encodings and reset values
`define CCB_LOAD_ZERO        2'h0
`define CCB_LOAD_PRD         2'h1
`define CCB_LOAD_EITHER      2'h2
`define CCB_LOAD_FREEZE      2'h3
`define CCB_ACT_NONE         2'h0
`define CCB_ACT_LOW          2'h1
`define CCB_ACT_HIGH         2'h2
`define CCB_ACT_TOGGLE       2'h3
`define CCB_RST_VAL          16'h0000
`define CCB_ZERO_COUNT       16'h0000
`endif

// [ccb_load_sel.v]
// Load strobe decoder: turns a load-select code and counter events into a one-cycle strobe.
// Assumes zero and period flags are single-cycle, synchronous to clk.
`timescale 1ns/100ps
`include "ccb_defines.vh"
module ccb_load_sel (
  // Selection.
  input  wire [1:0] load_sel_i,
  // Counter events.
  input  wire       at_zero_i,
  input  wire       at_period_i,
  // Strobe.
  output reg        strobe_o
);
  // ==========================================================================
  // Decode
  // Freeze blocks every load so software can stage values indefinitely.
  always @* begin
    case (load_sel_i)                                          // [RQ12]
      `CCB_LOAD_ZERO:   strobe_o = at_zero_i;
      `CCB_LOAD_PRD:    strobe_o = at_period_i;
      `CCB_LOAD_EITHER: strobe_o = at_zero_i | at_period_i;
      default:          strobe_o = 1'b0;
    endcase
  end
endmodule // ccb_load_sel

// [ccb_tb_tbase.sv]
// ==========================================================================
// Time-base model: holds a count that the bench sets, and a fixed period.
// Assumes the bench steps the count so that each match lasts one cycle.
`timescale 1ns/100ps
module ccb_tb_tbase #(
  parameter PRD = 16'h0009
) (
  input  logic        clk_i,
  input  logic        rst_i,
  input  logic        set_i,
  input  logic [15:0] set_val_i,
  output logic [15:0] count_o,
  output logic [15:0] period_o
);
  // Holding the count lets a test park it off any match point.
  always @(posedge clk_i) begin
    if (rst_i) count_o <= 16'h0000;
    else if (set_i) count_o <= set_val_i;
  end
  assign period_o = PRD;
endmodule // ccb_tb_tbase

// [ccb_top.v]
// Compare-B unit with buffered compare value, Wishbone registers and a small action stage.
// Assumes the time-base counter and period come from outside the module and are synchronous to clk_i.
//
// Summary of operation
// [RQ1] Hold a 16-bit active compare-B value, compared to the count every cycle.
// [RQ2] Equality of count and active value raises a compare-B event.
// [RQ3] The event goes to the action stage which acts on either output.
// [RQ4] Per output the event is ignored, forces low, forces high or toggles.
// [RQ5] After reset compare-B is buffered with its buffer-select bit at zero.
// [RQ6] With buffer-select zero, software reads and writes reach the buffer copy.
// [RQ7] Buffered mode copies buffer to active only on the selected counter event.
// [RQ8] A readable pending flag shows the buffer holds an unloaded value.
// [RQ9] With buffer-select one, software reads and writes reach the active value.
// [RQ10] Active and buffer share one address; buffer-select alone picks between them.
// [RQ11] Control bit 9 is B pending, bit 8 A pending, upper bits read zero.
// [RQ12] Load select 00 zero, 01 period, 10 either, 11 freeze.
// [RQ13] Pending clears on a load strobe; writes while pending replace the buffer.
// [RQ14] Control bit 6 B select, bit 4 A select, 3-2 B load, 1-0 A load.
// [RQ15] Values and writable control fields reset to zero, load at counter zero.
// [RQ16] Buffered writes set pending; a write in a load-strobe cycle keeps it set.
`timescale 1ns/100ps
`include "ccb_defines.vh"
module ccb_top #(
  parameter CW = 16
) (
  // Clock and reset.
  input  wire          clk_i,
  input  wire          rst_i,
  // Wishbone slave.
  input  wire          wb_cyc_i,
  input  wire          wb_stb_i,
  input  wire          wb_we_i,
  input  wire [3:0]    wb_adr_i,
  input  wire [3:0]    wb_sel_i,
  input  wire [31:0]   wb_dat_i,
  output reg  [31:0]   wb_dat_o,
  output reg           wb_ack_o,
  // Time base.
  input  wire [CW-1:0] timebase_count_i,
  input  wire [CW-1:0] timebase_period_i,
  // Compare events and outputs.
  output reg           cmp_b_event_o,
  output reg           output_a_o,
  output reg           output_b_o
);
  // ==========================================================================
  // State
  // Register map on the byte address: 0x0 compare A, 0x4 compare B, 0x8 control,
  // 0xC action control. Action bits 1-0 steer output A and bits 3-2 output B.
  // Compare A is kept only so that its pending flag and buffer select read back sensibly.
  reg  [CW-1:0]        b_active_r;
  reg  [CW-1:0]        b_buffer_r;
  reg  [CW-1:0]        a_active_r;
  reg  [CW-1:0]        a_buffer_r;
  reg                  b_buffer_select_r;
  reg                  a_buffer_select_r;
  reg  [1:0]           b_load_select_r;
  reg  [1:0]           a_load_select_r;
  reg                  b_pending_flag_r;
  reg                  a_pending_flag_r;
  reg  [`CCB_ACT_W-1:0] action_ctrl_r;
  // Next values, worked out combinationally and taken at each rising edge.
  reg  [CW-1:0]        b_active_nxt;
  reg  [CW-1:0]        b_buffer_nxt;
  reg                  b_pending_nxt;
  reg  [CW-1:0]        a_active_nxt;
  reg  [CW-1:0]        a_buffer_nxt;
  reg                  a_pending_nxt;
  reg                  b_buffer_select_nxt;
  reg                  a_buffer_select_nxt;
  reg  [1:0]           b_load_select_nxt;
  reg  [1:0]           a_load_select_nxt;
  reg  [`CCB_ACT_W-1:0] action_ctrl_nxt;
  reg  [31:0]          rd_dat_nxt;
  wire                 b_strobe;
  wire                 a_strobe;
  wire                 at_zero;
  wire                 at_period;
  wire                 b_match;
  wire                 output_a_nxt;
  wire                 output_b_nxt;
  wire                 b_val_wr;
  wire                 a_val_wr;
  wire                 req;
  wire                 wr;
  wire                 wr_lo;
  wire [15:0]          wdat;
  wire [15:0]          ctrl_rd;

  // Merges the low byte lanes into a 16-bit value; unselected lanes keep the old bits.
  function [15:0] merge16;
    input [15:0] old_v;
    input [15:0] new_v;
    input [1:0]  sel;
    begin
      merge16 = {sel[1] ? new_v[15:8] : old_v[15:8], sel[0] ? new_v[7:0] : old_v[7:0]};
    end
  endfunction

  // Picks the copy that software sees: the active value when the buffer is bypassed.
  function [15:0] visible16;
    input        bypass;
    input [15:0] active_v;
    input [15:0] buffer_v;
    begin
      visible16 = bypass ? active_v : buffer_v;
    end
  endfunction

  // ==========================================================================
  // Counter events
  assign at_zero   = (timebase_count_i == `CCB_ZERO_COUNT);
  assign at_period = (timebase_count_i == timebase_period_i);
  assign b_match   = (timebase_count_i == b_active_r);          // [RQ1] [RQ2]

  ccb_load_sel u_b_load (
    .load_sel_i  (b_load_select_r),
    .at_zero_i   (at_zero),
    .at_period_i (at_period),
    .strobe_o    (b_strobe)
  );

  ccb_load_sel u_a_load (
    .load_sel_i  (a_load_select_r),
    .at_zero_i   (at_zero),
    .at_period_i (at_period),
    .strobe_o    (a_strobe)
  );

  // ==========================================================================
  // Bus decode
  // Only one ack per request: the ack register drops the cycle after it rises.
  assign req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr    = req & wb_we_i;
  assign wr_lo = |wb_sel_i[1:0];
  assign wdat  = wb_dat_i[15:0];
  // Value writes need at least one of the two low byte lanes.
  assign b_val_wr = wr & wr_lo & (wb_adr_i == `CCB_OFS_CMP_B);      // [RQ10]
  assign a_val_wr = wr & wr_lo & (wb_adr_i == `CCB_OFS_CMP_A);
  assign ctrl_rd = {6'h00, b_pending_flag_r, a_pending_flag_r, 1'b0,    // [RQ11]
                    b_buffer_select_r, 1'b0, a_buffer_select_r,         // [RQ14]
                    b_load_select_r, a_load_select_r};

  // ==========================================================================
  // Compare-B value and pending flag
  // A write in the strobe cycle lands in the buffer and stays pending, so it is not lost.
  always @* begin
    b_active_nxt  = b_active_r;
    b_buffer_nxt  = b_buffer_r;
    b_pending_nxt = b_pending_flag_r;
    if (!b_buffer_select_r && b_strobe) begin
      b_active_nxt  = b_buffer_r;                               // [RQ7]
      b_pending_nxt = 1'b0;                                     // [RQ13] [RQ16]
    end
    if (b_val_wr) begin                                         // [RQ10]
      if (b_buffer_select_r) begin
        b_active_nxt = merge16(b_active_r, wdat, wb_sel_i[1:0]);    // [RQ9]
      end else begin
        b_buffer_nxt  = merge16(b_buffer_r, wdat, wb_sel_i[1:0]);   // [RQ6] [RQ13]
        b_pending_nxt = 1'b1;                                   // [RQ8] [RQ16]
      end
    end
  end

  // Compare-B registers; reset leaves the value zero with nothing pending.
  always @(posedge clk_i) begin
    if (rst_i) begin
      b_active_r       <= `CCB_RST_VAL;                         // [RQ15]
      b_buffer_r       <= `CCB_RST_VAL;
      b_pending_flag_r <= 1'b0;
    end else begin
      b_active_r       <= b_active_nxt;
      b_buffer_r       <= b_buffer_nxt;
      b_pending_flag_r <= b_pending_nxt;
    end
  end

  // ==========================================================================
  // Compare-A value, kept only so its pending flag and mode have meaning.
  always @* begin
    a_active_nxt  = a_active_r;
    a_buffer_nxt  = a_buffer_r;
    a_pending_nxt = a_pending_flag_r;
    if (!a_buffer_select_r && a_strobe) begin
      a_active_nxt  = a_buffer_r;
      a_pending_nxt = 1'b0;
    end
    if (a_val_wr) begin
      if (a_buffer_select_r) begin
        a_active_nxt = merge16(a_active_r, wdat, wb_sel_i[1:0]);
      end else begin
        a_buffer_nxt  = merge16(a_buffer_r, wdat, wb_sel_i[1:0]);
        a_pending_nxt = 1'b1;
      end
    end
  end

  // Compare-A registers, reset like compare B.
  always @(posedge clk_i) begin
    if (rst_i) begin
      a_active_r       <= `CCB_RST_VAL;
      a_buffer_r       <= `CCB_RST_VAL;
      a_pending_flag_r <= 1'b0;
    end else begin
      a_active_r       <= a_active_nxt;
      a_buffer_r       <= a_buffer_nxt;
      a_pending_flag_r <= a_pending_nxt;
    end
  end

  // ==========================================================================
  // Control and action registers
  // Both live in byte lane 0, so a write without that lane leaves them alone.
  always @* begin
    b_buffer_select_nxt = b_buffer_select_r;
    a_buffer_select_nxt = a_buffer_select_r;
    b_load_select_nxt   = b_load_select_r;
    a_load_select_nxt   = a_load_select_r;
    action_ctrl_nxt     = action_ctrl_r;
    if (wr && wb_sel_i[0]) begin
      if (wb_adr_i == `CCB_OFS_CTRL) begin
        b_buffer_select_nxt = wb_dat_i[`CCB_B_BUF_BIT];         // [RQ14]
        a_buffer_select_nxt = wb_dat_i[`CCB_A_BUF_BIT];
        b_load_select_nxt   = wb_dat_i[`CCB_B_LOAD_HI:`CCB_B_LOAD_LO];
        a_load_select_nxt   = wb_dat_i[`CCB_A_LOAD_HI:`CCB_A_LOAD_LO];
      end else if (wb_adr_i == `CCB_OFS_ACT_A) begin
        action_ctrl_nxt = wb_dat_i[`CCB_ACT_W-1:0];
      end
    end
  end

  // Reset gives buffered mode, loads at counter zero and every action off.
  always @(posedge clk_i) begin
    if (rst_i) begin
      b_buffer_select_r <= 1'b0;                                // [RQ5] [RQ15]
      a_buffer_select_r <= 1'b0;
      b_load_select_r   <= `CCB_LOAD_ZERO;                      // [RQ15]
      a_load_select_r   <= `CCB_LOAD_ZERO;
      action_ctrl_r     <= {`CCB_ACT_W{1'b0}};
    end else begin
      b_buffer_select_r <= b_buffer_select_nxt;
      a_buffer_select_r <= a_buffer_select_nxt;
      b_load_select_r   <= b_load_select_nxt;
      a_load_select_r   <= a_load_select_nxt;
      action_ctrl_r     <= action_ctrl_nxt;
    end
  end

  // ==========================================================================
  // Bus answer: one wait state, ack a cycle after the request; unmapped offsets read zero and ignore writes.
  // Read data is chosen here and held in the output register until the next read.
  always @* begin
    case (wb_adr_i)
      `CCB_OFS_CMP_A: rd_dat_nxt = {16'h0000, visible16(a_buffer_select_r, a_active_r, a_buffer_r)};
      `CCB_OFS_CMP_B: rd_dat_nxt = {16'h0000, visible16(b_buffer_select_r, b_active_r, b_buffer_r)};
      `CCB_OFS_CTRL:  rd_dat_nxt = {16'h0000, ctrl_rd};
      `CCB_OFS_ACT_A: rd_dat_nxt = {28'h0000000, action_ctrl_r};
      default:        rd_dat_nxt = 32'h00000000;
    endcase
  end

  // The answer register: ack follows a taken request by one cycle.  [RQ6] [RQ9]
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req;
      if (req && !wb_we_i) begin
        wb_dat_o <= rd_dat_nxt;
      end
    end
  end

  // ==========================================================================
  // Event and action stage
  ccb_action u_act_a (
    .act_i   (action_ctrl_r[`CCB_ACT_OUTA_HI:`CCB_ACT_OUTA_LO]),
    .event_i (b_match),
    .level_i (output_a_o),
    .level_o (output_a_nxt)
  );

  ccb_action u_act_b (
    .act_i   (action_ctrl_r[`CCB_ACT_OUTB_HI:`CCB_ACT_OUTB_LO]),
    .event_i (b_match),
    .level_i (output_b_o),
    .level_o (output_b_nxt)
  );

  // The event is registered; a count that rests on the value repeats it each cycle.
  always @(posedge clk_i) begin
    if (rst_i) begin
      cmp_b_event_o <= 1'b0;
      output_a_o    <= 1'b0;
      output_b_o    <= 1'b0;
    end else begin
      cmp_b_event_o <= b_match;                                 // [RQ2] [RQ3]
      output_a_o    <= output_a_nxt;                            // [RQ3] [RQ4]
      output_b_o    <= output_b_nxt;
    end
  end
endmodule // ccb_top

// [ccb_top_monitor.sv]
// ==========================================================================
// Port checker for the compare-B unit, bound to its top module.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
module ccb_mon #(
  parameter CW = 16
) (
  input logic          clk_i,
  input logic          rst_i,
  input logic          wb_cyc_i,
  input logic          wb_stb_i,
  input logic          wb_we_i,
  input logic [3:0]    wb_adr_i,
  input logic [31:0]   wb_dat_o,
  input logic          wb_ack_o,
  input logic          cmp_b_event_o,
  input logic          output_a_o,
  input logic          output_b_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // A request is taken when strobed while no answer is out.
  sequence s_take; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_rd(a); s_take ##0 (!wb_we_i && wb_adr_i == a); endsequence
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  property p_ack_next; s_take |=> wb_ack_o; endproperty
  property p_ack_cause; !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o; endproperty
  property p_out_a; $changed(output_a_o) |-> cmp_b_event_o; endproperty
  property p_out_b; $changed(output_b_o) |-> cmp_b_event_o; endproperty
  property p_ctrl_rd;
    s_rd(4'h8) |=> wb_ack_o && wb_dat_o[31:10] == 22'h0 && !wb_dat_o[7] && !wb_dat_o[5];
  endproperty
  property p_val_rd; s_rd(4'h4) |=> wb_dat_o[31:16] == 16'h0; endproperty
  property p_unmap; s_rd(4'h2) |=> wb_dat_o == 32'h0; endproperty
  // Reset must clear outputs even though the default disable is reset.
  property p_rst;
    disable iff (1'b0) rst_i |=> !cmp_b_event_o && !output_a_o && !output_b_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  a_ack_next: assert property (p_ack_next) else $error("no ack after request");
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  a_out_a: assert property (p_out_a) else $error("output a moved without event");
  a_out_b: assert property (p_out_b) else $error("output b moved without event");
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("reserved control bits set");
  a_val_rd: assert property (p_val_rd) else $error("compare upper bits set");
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
endmodule // ccb_mon
bind ccb_top ccb_mon #(.CW(CW)) u_mon (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .cmp_b_event_o(cmp_b_event_o), .output_a_o(output_a_o),
  .output_b_o(output_b_o));

// [testbench.sv]
// ==========================================================================
// Self-checking bench for the compare-B unit over classic Wishbone.
// Assumes the bench parks the time-base count at 5 between tests, a value no test matches.
`timescale 1ns/100ps
module testbench;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, set = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, dat_o;
  logic        ack, evt, out_a, out_b;
  logic [15:0] set_val = 16'h0000, cnt, prd;
  int          num_errors = 0, total_checks = 0;
  always #10 clk_i = ~clk_i;
  ccb_tb_tbase i_tb (.clk_i(clk_i), .rst_i(rst_i), .set_i(set), .set_val_i(set_val),
    .count_o(cnt), .period_o(prd));
  ccb_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .timebase_count_i(cnt), .timebase_period_i(prd), .cmp_b_event_o(evt),
    .output_a_o(out_a), .output_b_o(out_b));
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // One classic cycle; the request holds until ack is sampled high.
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc, stb, we, adr, wdat} <= {1'b1, 1'b1, w, a, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) check(1'b0, 1'b1, "ack wait");
    rdat = dat_o;
    {cyc, stb, we} <= 3'h0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0);
    check(rdat, exp, what);
  endtask
  // Parks the count at v; the unit has acted on it when this returns.
  task automatic set_cnt(input logic [15:0] v);
    @(posedge clk_i);
    {set, set_val} <= {1'b1, v};
    @(posedge clk_i);
    set <= 1'b0;
    @(posedge clk_i);
  endtask
  // Count equals v for one cycle only, so a toggle acts once.
  task automatic pulse(input logic [15:0] v, input logic [2:0] exp);
    @(posedge clk_i);
    {set, set_val} <= {1'b1, v};
    @(posedge clk_i);
    set_val <= 16'h0005;
    @(posedge clk_i);
    set <= 1'b0;
    #1 check({29'h0, evt, out_a, out_b}, {29'h0, exp}, "event/outputs");
  endtask
  task automatic t_buffer;
    rd(4'h8, 32'h0, "ctrl reset");
    rd(4'h4, 32'h0, "value reset");
    set_cnt(16'h0005);
    bus(1'b1, 4'h4, 32'h9);
    bus(1'b1, 4'h4, 32'h7);
    rd(4'h8, 32'h200, "pending set");
    rd(4'h4, 32'h7, "buffer read");
    pulse(16'h0007, 3'h0);
    set_cnt(16'h0000);
    set_cnt(16'h0005);
    rd(4'h8, 32'h0, "pending cleared");
    pulse(16'h0007, 3'h4);
    $display("buffer test done");
  endtask
  task automatic t_loads;
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      bus(1'b1, 4'h8, {28'h0, c, 2'h0});
      bus(1'b1, 4'h4, {30'h40, c});
      set_cnt(16'h0000);
      rd(4'h8, {22'h0, c[0], 5'h0, c, 2'h0}, "after zero");
      set_cnt(prd);
      rd(4'h8, {22'h0, c == 2'h3, 5'h0, c, 2'h0}, "after period");
      set_cnt(16'h0005);
    end
    $display("load select test done");
  endtask
  task automatic t_direct;
    logic [1:0] codes[4] = '{2'h2, 2'h0, 2'h1, 2'h3};
    logic       lvl[4] = '{1'b1, 1'b1, 1'b0, 1'b1};
    bus(1'b1, 4'h8, 32'h40);
    bus(1'b1, 4'h4, 32'h3);
    rd(4'h4, 32'h3, "direct read");
    rd(4'h8, 32'h240, "pending kept");
    rd(4'h2, 32'h0, "unmapped");
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 4'hC, {28'h0, codes[i], codes[i]});
      pulse(16'h0003, {1'b1, lvl[i], lvl[i]});
    end
    $display("direct and action test done");
  endtask
  task automatic results;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Main sequence: reset for four cycles, then the tests.
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_buffer();
    t_loads();
    t_direct();
    results();
  end
  // The tests need well under a thousand cycles; this allows ten times more.
  initial begin
    #200000;
    check(1'b0, 1'b1, "watchdog");
    results();
  end
endmodule // testbench
